// ==== adc_pkg.sv ====
// Functional notes
// - Clearing the power-on bit switches the converter off and stops conversions.
// - Processor wait mode leaves converter operation, configuration and status untouched.
// - Halt disables the converter; after wakeup results settle for a stabilisation time.
// - Bit 7 of control register is read-only completion flag, 1 when conversion complete.
// - Reading result-high or writing the control register clears the completion flag.
// - Slow and speed bits choose converter clock: /2, /1, or /4 when slow.
// - Control bit 5 is read/write power-on: 1 switches converter on, 0 off.
// - Three-bit channel field selects input 0 to 4 by codes 000 to 100.
// - A control write while powered aborts, clears completion and restarts conversion.
// - Result-high register reads result bits 9 down to 2, bit 9 on top.
// - Result-low reads result bits 1:0, slow bit at 3, all else zero.
// - After reset all three converter registers read zero.
// - Powered converter repeats sample and conversion phases, flagging each finished result.
// - Conversion phase lasts 8 approximation cycles with sample capacitor disconnected.
// - Input above reference saturates result to all ones; below reference gives zero.
package adc_pkg;

    // ==========================================================
    // Register map
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 8;
    localparam int          RES_W       = 10;
    localparam logic [7:0]  OFS_CSR     = 8'h34;
    localparam logic [7:0]  OFS_RES_HI  = 8'h35;
    localparam logic [7:0]  OFS_RES_LO  = 8'h36;
    localparam logic [7:0]  OFS_STATUS  = 8'h37;
    localparam logic [7:0]  OFS_MASK    = 8'h38;
    localparam logic [7:0]  REG_RESET   = 8'h00;

    // ==========================================================
    // Field positions
    localparam int          EOC_BIT     = 7;
    localparam int          SPEED_BIT   = 6;
    localparam int          PWR_BIT     = 5;
    localparam int          SLOW_BIT    = 3;
    localparam int          DONE_BIT    = 0;
    localparam int          SETTLE_BIT  = 1;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          WAKEUP_SETTLE_NS = 20000;
    localparam int          SETTLE_CYCLES    =
        (WAKEUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETTLE_W         = 12;
    localparam logic [11:0] SETTLE_LOAD      = 12'(SETTLE_CYCLES);
    localparam int          CNT_W            = 4;
    localparam logic [3:0]  SAMPLE_TICKS     = 4'h3;
    localparam logic [3:0]  HOLD_TICKS       = 4'h8;
    localparam logic [9:0]  RES_FULL         = 10'h3FF;
    localparam logic [9:0]  RES_ZERO         = 10'h000;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'h0,
        SEQ_SAMPLE = 2'h1,
        SEQ_HOLD   = 2'h3
    } seq_state_t;

    // ==========================================================
    // Helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    function automatic logic [9:0] saturate(input logic over, input logic under,
                                            input logic [9:0] raw);
        if (over)
            return RES_FULL;
        if (under)
            return RES_ZERO;
        return raw;
    endfunction : saturate

endpackage : adc_pkg

// ==== conv_seq_if.sv ====
`timescale 1ns/10ps
interface conv_seq_if;
    logic run;
    logic restart;
    logic tick;
    logic sample_en;
    logic sar_step;
    logic done;

    modport ctrl (output run, output restart, output tick,
                  input sample_en, input sar_step, input done);
    modport seq  (input run, input restart, input tick,
                  output sample_en, output sar_step, output done);
endinterface : conv_seq_if

// ==== conv_sequencer.sv ====
`timescale 1ns/10ps
module conv_sequencer (
    input wire logic clock,
    input wire logic sys_rst,
    conv_seq_if.seq  link
);
    import adc_pkg::*;

    typedef struct packed {
        seq_state_t       state;
        logic [CNT_W-1:0] cnt;
        logic             done;
    } seq_t;

    seq_t st_r;
    seq_t st_nxt;

    assign link.sample_en = (st_r.state == SEQ_SAMPLE);
    assign link.sar_step  = (st_r.state == SEQ_HOLD) && link.tick;
    assign link.done      = st_r.done;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (!link.run) begin
            st_nxt.state = SEQ_IDLE;
            st_nxt.cnt   = '0;
        end else if (link.restart) begin
            st_nxt.state = SEQ_SAMPLE;
            st_nxt.cnt   = '0;
        end else begin
            unique case (st_r.state)
                SEQ_IDLE: begin
                    st_nxt.state = SEQ_SAMPLE;
                    st_nxt.cnt   = '0;
                end
                SEQ_SAMPLE: begin
                    if (link.tick) begin
                        if (st_r.cnt == SAMPLE_TICKS - 4'h1) begin
                            st_nxt.state = SEQ_HOLD;
                            st_nxt.cnt   = '0;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 4'h1;
                        end
                    end
                end
                SEQ_HOLD: begin
                    if (link.tick) begin
                        if (st_r.cnt == HOLD_TICKS - 4'h1) begin
                            // Back to sampling: conversions repeat while powered
                            st_nxt.state = SEQ_SAMPLE;
                            st_nxt.cnt   = '0;
                            st_nxt.done  = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    st_nxt.state = SEQ_IDLE;
                    st_nxt.cnt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ==========================================================
    // Checks
    a_hold_eight_steps: assert property (@(posedge clock) disable iff (sys_rst)
        st_r.done |-> $past(st_r.state) == SEQ_HOLD && $past(st_r.cnt) == HOLD_TICKS - 4'h1)
        else $error("completion without eight hold steps");
    a_sample_disconnected: assert property (@(posedge clock) disable iff (sys_rst)
        link.sar_step |-> !link.sample_en)
        else $error("approximation step while sampling");

endmodule : conv_sequencer

// ==== adc_control_and_result_regs.sv ====
`timescale 1ns/10ps
module adc_control_and_result_regs (
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    input  wire logic [adc_pkg::ADDR_W-1:0] addr,
    input  wire logic [adc_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr_stb,
    input  wire logic                       rd_stb,
    output      logic [adc_pkg::DATA_W-1:0] rdata,
    input  wire logic                       halt_mode,
    output      logic                       converter_enable,
    output      logic [2:0]                 input_select,
    output      logic                       sample_en,
    output      logic                       sar_step,
    input  wire logic [adc_pkg::RES_W-1:0]  core_result,
    input  wire logic                       core_over_high,
    input  wire logic                       core_under_low,
    output      logic                       irq
);
    import adc_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic                speed;
        logic                power_on;
        logic [2:0]          input_select;
        logic                slow;
        logic                eoc;
        logic [RES_W-1:0]    result;
        logic                done_sticky;
        logic                mask;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          div_cnt;
        logic [SETTLE_W-1:0] settle_cnt;
        logic                halt_d;
        logic                analog_en;
    } ctrl_t;

    ctrl_t s_r;
    ctrl_t s_nxt;

    logic csr_wr;
    logic lo_wr;
    logic mask_wr;
    logic hi_rd;
    logic status_rd;
    logic clear_eoc;
    logic settling;

    conv_seq_if link();

    conv_sequencer u_seq (
        .clock   (clock),
        .sys_rst (sys_rst),
        .link    (link.seq)
    );

    // ==========================================================
    // Bus decode
    assign csr_wr    = wr_stb && hit(addr, OFS_CSR);
    assign lo_wr     = wr_stb && hit(addr, OFS_RES_LO);
    assign mask_wr   = wr_stb && hit(addr, OFS_MASK);
    assign hi_rd     = rd_stb && hit(addr, OFS_RES_HI);
    assign status_rd = rd_stb && hit(addr, OFS_STATUS);
    assign clear_eoc = csr_wr || hi_rd;
    assign settling  = (s_r.settle_cnt != '0);

    // ==========================================================
    // Sequencer control
    // Slow overrides speed; the divider runs free so a rate change needs no resync
    assign link.tick = s_r.slow  ? (s_r.div_cnt == 2'h3) :
                       s_r.speed ? 1'b1 : s_r.div_cnt[0];
    // Wait mode has no input here on purpose: only power, halt and settling gate
    assign link.run = s_r.power_on && !halt_mode && !settling;
    assign link.restart = csr_wr && wdata[PWR_BIT];

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt         = s_r;
        s_nxt.div_cnt = s_r.div_cnt + 2'h1;
        s_nxt.halt_d  = halt_mode;

        // Results right after halt are not trusted until the settle count runs out
        if (s_r.halt_d && !halt_mode)
            s_nxt.settle_cnt = SETTLE_LOAD;
        else if (settling)
            s_nxt.settle_cnt = s_r.settle_cnt - 12'h001;

        if (csr_wr) begin
            // Reserved bits 4:3 are not stored and read back as zero
            s_nxt.speed        = wdata[SPEED_BIT];
            s_nxt.power_on     = wdata[PWR_BIT];
            s_nxt.input_select = wdata[2:0];
        end
        if (lo_wr)
            s_nxt.slow = wdata[SLOW_BIT];
        if (mask_wr)
            s_nxt.mask = wdata[DONE_BIT];

        s_nxt.analog_en = s_nxt.power_on && !halt_mode;

        if (clear_eoc)
            s_nxt.eoc = 1'b0;
        if (status_rd)
            s_nxt.done_sticky = 1'b0;
        // A completion in the same cycle as a clear wins, so no result is lost
        if (link.done) begin
            s_nxt.eoc         = 1'b1;
            s_nxt.done_sticky = 1'b1;
            s_nxt.result      = saturate(core_over_high, core_under_low,
                                         core_result);
        end

        s_nxt.rdata = REG_RESET;
        if (rd_stb) begin
            case (addr)
                OFS_CSR:    s_nxt.rdata = {s_r.eoc, s_r.speed, s_r.power_on,
                                           2'b00, s_r.input_select};
                OFS_RES_HI: s_nxt.rdata = s_r.result[9:2];
                OFS_RES_LO: s_nxt.rdata = {4'h0, s_r.slow, 1'b0,
                                           s_r.result[1:0]};
                OFS_STATUS: s_nxt.rdata = {6'h00, settling, s_r.done_sticky};
                OFS_MASK:   s_nxt.rdata = {7'h00, s_r.mask};
                default:    s_nxt.rdata = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // ==========================================================
    // Outputs
    assign rdata            = s_r.rdata;
    assign converter_enable = s_r.analog_en;
    assign input_select     = s_r.input_select;
    assign sample_en        = link.sample_en;
    assign sar_step         = link.sar_step;
    // Mask resets to zero, so the block stays silent unless software opts in
    assign irq              = s_r.done_sticky && s_r.mask;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_eoc_after_done: assert property (
        link.done |=> s_r.eoc)
        else $error("completion flag not set after conversion");

    a_eoc_clear_read: assert property (
        (clear_eoc && !link.done) |=> !s_r.eoc)
        else $error("completion flag not cleared by read or write");

    a_write_restarts: assert property (
        (csr_wr && wdata[PWR_BIT] && s_r.power_on && !halt_mode && !settling)
        |=> link.sample_en ##1 link.sample_en)
        else $error("control write did not restart sampling");

    a_off_stops: assert property (
        (!s_r.power_on [*2]) |-> !link.sample_en && !link.sar_step)
        else $error("converter active while powered off");

    a_power_bit: assert property (
        csr_wr && !halt_mode |=> converter_enable == $past(wdata[PWR_BIT]))
        else $error("enable output does not follow power bit");

    a_halt_off: assert property (
        halt_mode ##1 halt_mode |-> !converter_enable && !link.sample_en)
        else $error("converter running in halt");

    a_settle_load: assert property (
        $fell(halt_mode) |=> s_r.settle_cnt == SETTLE_LOAD && !link.run)
        else $error("no settle interval after halt");

    a_slow_rate: assert property (
        s_r.slow && link.tick |-> s_r.div_cnt == 2'h3)
        else $error("slow clock not divided by four");

    a_half_rate: assert property (
        (!s_r.slow && !s_r.speed && link.tick) ##1 (!s_r.slow && !s_r.speed)
        |-> !link.tick)
        else $error("half rate clock ticks twice in a row");

    a_channel_sel: assert property (
        csr_wr |=> input_select == $past(wdata[2:0]))
        else $error("channel select not taken from write");

    a_hi_layout: assert property (
        hi_rd |=> rdata == $past(s_r.result[9:2]))
        else $error("result high layout wrong");

    a_lo_layout: assert property (
        rd_stb && hit(addr, OFS_RES_LO)
        |=> rdata[7:4] == 4'h0 && rdata[2] == 1'b0 &&
            rdata[1:0] == $past(s_r.result[1:0]) && rdata[3] == $past(s_r.slow))
        else $error("result low layout wrong");

    a_reserved_zero: assert property (
        rd_stb && hit(addr, OFS_CSR) |=> rdata[4:3] == 2'b00 &&
            rdata[EOC_BIT] == $past(s_r.eoc))
        else $error("control read layout wrong");

    a_saturate_high: assert property (
        link.done && core_over_high |=> s_r.result == RES_FULL)
        else $error("over range result not saturated");

    a_reset_zero: assert property (disable iff (1'b0)
        $past(sys_rst) && !sys_rst |-> !s_r.eoc && !s_r.power_on &&
            s_r.input_select == 3'h0 && !s_r.slow && !s_r.speed && rdata == REG_RESET)
        else $error("register not zero after reset");

    a_no_irq_masked: assert property (
        !s_r.mask |-> !irq)
        else $error("interrupt raised while masked");

    a_read_one_cycle: assert property (
        !rd_stb |=> rdata == REG_RESET)
        else $error("read data outside answer cycle");

    a_settle_quiet: assert property (
        settling ##1 settling |-> !link.sample_en && !link.sar_step)
        else $error("conversion during settle interval");

    // The settle span is far too long to unroll, so the counter itself is watched
    a_settle_count: assert property (
        settling && !(s_r.halt_d && !halt_mode)
        |=> s_r.settle_cnt == $past(s_r.settle_cnt) - 12'h001)
        else $error("settle count not running down");

    a_halt_enable: assert property (
        halt_mode |=> !converter_enable)
        else $error("enable output high in halt");

    a_slow_write: assert property (
        lo_wr |=> s_r.slow == $past(wdata[SLOW_BIT]))
        else $error("slow bit not taken from write");

    a_result_kept: assert property (
        !link.done |=> s_r.result == $past(s_r.result))
        else $error("result changed without completion");

    a_saturate_low: assert property (
        link.done && core_under_low && !core_over_high |=> s_r.result == RES_ZERO)
        else $error("under range result not zero");

    a_status_clear: assert property (
        status_rd && !link.done |=> !s_r.done_sticky)
        else $error("done status not cleared by read");

    c_conversion_done: cover property (link.done ##[1:40] hi_rd);
    c_abort_in_hold: cover property (link.sar_step ##1 csr_wr);
    c_clear_race: cover property (link.done && clear_eoc);
    c_wake_settled: cover property ($fell(settling) && !halt_mode);
    c_restart_run: cover property ((link.restart && link.run) ##1 link.sample_en);

endmodule : adc_control_and_result_regs

// ==== adc_core_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// Analog core stand-in: fixed code per channel, forced range faults
module adc_core_model (
    input  wire logic       clock,
    input  wire logic       enable,
    input  wire logic [2:0] chan,
    input  wire logic       sample,
    input  wire logic       step,
    input  wire logic [1:0] fault,
    output      logic [9:0] result,
    output      logic       over,
    output      logic       under,
    output      int         steps,
    output      int         bad
);
    int cnt = 0;
    int n_steps = 0;
    int n_bad = 0;
    assign steps = n_steps;
    assign bad   = n_bad;
    // An unpowered core gives no stable code, so show a toggling one
    always_comb result = enable ? {chan, 7'h5A} : {5'h15, {5{clock}}};
    assign over  = fault[0];
    assign under = fault[1];
    always @(posedge clock) begin
        if (sample)
            cnt <= 0;
        else if (step)
            cnt <= cnt + 1;
        if (sample && cnt != 0)
            n_steps <= cnt;
        if (sample && step)
            n_bad <= n_bad + 1;
    end
endmodule : adc_core_model

// ==== tb_adc_control_and_result_regs.sv ====
`timescale 1ns/10ps
module tb_adc_control_and_result_regs;
    import adc_pkg::*;
    logic       clock = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0, halt_mode = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic       converter_enable, sample_en, sar_step, irq, over, under;
    logic [2:0] input_select;
    logic [9:0] core_result, exp;
    logic [1:0] fault = 2'h0;
    logic [7:0] regs [4] = '{OFS_CSR, OFS_RES_HI, OFS_RES_LO, 8'hC0};
    int         fail_count = 0, n_checks = 0, steps, bad, g;

    initial forever #5 clock = ~clock;

    adc_control_and_result_regs dut (.clock(clock), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .halt_mode(halt_mode), .converter_enable(converter_enable),
        .input_select(input_select), .sample_en(sample_en), .sar_step(sar_step),
        .core_result(core_result), .core_over_high(over), .core_under_low(under),
        .irq(irq));
    adc_core_model core (.clock(clock), .enable(converter_enable), .chan(input_select),
        .sample(sample_en), .step(sar_step), .fault(fault), .result(core_result),
        .over(over), .under(under), .steps(steps), .bad(bad));

    // ==========================================================
    // Bus tasks and comparison
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string m);
        n_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h want %h", $time, m, seen, want);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic wait_eoc(input int lim);
        v = 8'h00;
        for (int i = 0; i < lim && v[7] !== 1'b1; i++)
            rd(OFS_CSR, v);
        check({7'h0, v[7]}, 8'h01, "completion flag");
    endtask : wait_eoc

    // Spacing of the first two approximation steps after a restart
    task automatic gap(output int n);
        n = 0;
        @(posedge clock iff (sar_step === 1'b1));
        do begin
            @(posedge clock);
            n++;
        end while (sar_step !== 1'b1 && n < 20);
    endtask : gap

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    initial begin
        #500us;
        fail_count++;
        wrap_up();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(regs[i], v);
            check(v, REG_RESET, "reset value");
        end
        for (int ch = 0; ch < 5; ch++) begin
            wr(OFS_CSR, 8'h60 | 8'(ch));
            check({7'h0, converter_enable}, 8'h01, "power on");
            check({5'h0, input_select}, 8'(ch), "channel");
            rd(OFS_CSR, v);
            check(v & 8'h7F, 8'h60 | 8'(ch), "control readback");
            // A completion on the write edge still sets the flag; drop that stale result
            rd(OFS_RES_HI, v);
            wait_eoc(50);
            exp = {3'(ch), 7'h5A};
            rd(OFS_RES_LO, v);
            check(v, {6'h00, exp[1:0]}, "low result");
            rd(OFS_RES_HI, v);
            check(v, exp[9:2], "high result");
            rd(OFS_CSR, v);
            check({7'h0, v[7]}, 8'h00, "flag after high read");
        end
        check(8'(steps), 8'h08, "steps per conversion");
        for (int f = 1; f < 4; f++) begin
            @(posedge clock) fault <= 2'(f);
            wait_eoc(50);
            rd(OFS_RES_LO, v);
            check(v, f == 2 ? 8'h00 : 8'h03, "range low");
            rd(OFS_RES_HI, v);
            check(v, f == 2 ? 8'h00 : 8'hFF, "range high");
        end
        @(posedge clock) fault <= 2'h0;
        wait_eoc(50);
        wr(OFS_CSR, 8'h64);
        check({7'h0, sample_en}, 8'h01, "restart on write");
        rd(OFS_CSR, v);
        check(v, 8'h64, "flag cleared by write");
        for (int k = 0; k < 4; k++) begin
            wr(OFS_RES_LO, k[1] ? 8'h08 : 8'h00);
            wr(OFS_CSR, k[0] ? 8'h60 : 8'h20);
            gap(g);
            check(8'(g), k[1] ? 8'h04 : (k[0] ? 8'h01 : 8'h02), "tick spacing");
            rd(OFS_RES_LO, v);
            check(v & 8'hFC, k[1] ? 8'h08 : 8'h00, "slow bit");
        end
        wr(OFS_RES_LO, 8'h00);
        wr(OFS_MASK, 8'h00);
        wait_eoc(50);
        check({7'h0, irq}, 8'h00, "masked interrupt");
        wr(OFS_CSR, 8'h00);
        check({7'h0, converter_enable}, 8'h00, "power off");
        wr(OFS_MASK, 8'h01);
        repeat (2) @(posedge clock);
        #1 check({7'h0, irq}, 8'h01, "interrupt raised");
        rd(OFS_STATUS, v);
        check({7'h0, v[DONE_BIT]}, 8'h01, "done status");
        g = 0;
        repeat (50) @(posedge clock) g += (sar_step === 1'b1);
        check({7'h0, irq}, 8'h00, "interrupt cleared");
        check(8'(g), 8'h00, "no steps while off");
        wr(OFS_CSR, 8'h60);
        @(posedge clock) halt_mode <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check({7'h0, converter_enable}, 8'h00, "halt disables");
        @(posedge clock) halt_mode <= 1'b0;
        repeat (3) @(posedge clock);
        rd(OFS_STATUS, v);
        check({7'h0, v[SETTLE_BIT]}, 8'h01, "settling after halt");
        wait_eoc(1500);
        check(8'(bad), 8'h00, "sampling during steps");
        wrap_up();
    end
endmodule : tb_adc_control_and_result_regs
